/* File: pkg/fifo_port_pkg.sv */
/*
  constants and types for the cpu fifo port select block.
  assumes a single 100 mhz clock and a plain register port.
*/
package fifo_port_pkg;
  localparam logic [3:0]  REG_PORT_SEL_OFS  = 4'h0;
  localparam logic [3:0]  REG_PORT_DATA_OFS = 4'h4;
  localparam logic [3:0]  REG_PORT_STAT_OFS = 4'h8;
  localparam int          RESTART_BIT       = 14;
  localparam int          RSVD_HI_BIT       = 13;
  localparam int          RSVD_LO_BIT       = 12;
  localparam int          WIDTH_HI_BIT      = 11;
  localparam int          WIDTH_LO_BIT      = 10;
  localparam int          DIR_BIT           = 5;
  localparam int          PIPE_HI_BIT       = 2;
  localparam int          PIPE_LO_BIT       = 0;
  localparam logic [1:0]  WIDTH_RESET       = 2'h0;
  localparam logic [15:0] SEL_RESET         = 16'h0000;
  localparam int          BUF_DEPTH         = 64;

  typedef enum logic [1:0] {
    W8   = 2'b00,
    W16  = 2'b01,
    W32  = 2'b10,
    WBAD = 2'b11
  } port_width_t;

  typedef struct packed {
    logic       restart;
    port_width_t width;
    logic       dir;
    logic [2:0] pipe;
  } port_sel_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } word_t;
endpackage

/* File: hdl/usb_fifo_port_select_ctrl.sv */
/*
  cpu side fifo port select with pointer restart and access width.
  assumes a plain register port on clk_i; the serial engine on the far
  side drains transmit data through a two-entry skid buffer with valid
  and ready.
*/
// How it works
// - bit 14 write one restarts pointer in receive direction only
// - receive restart rereads current plane only
// - bits 13 and 12 read zero
// - width field bits 11:10, reset 00
// - transmit write blocks width widening
`timescale 1ns/1ps
module usb_fifo_port_select_ctrl
  import fifo_port_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic        plane_sel_i,
  input  wire logic        buffer_clear_cmd_i,
  input  wire logic        port_ready_flag_i,
  output logic      [31:0] tx_data_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic      [2:0]  current_pipe_select_o,
  output logic             control_pipe_direction_o
);
  localparam int PW = $clog2(DEPTH) + 1;

  port_sel_t        sel_q, sel_d;
  logic [PW-1:0]    ptr_q, ptr_d;
  logic             writing_q, writing_d;
  logic [31:0]      rdata_q, rdata_d;
  logic [7:0]       mem [2][DEPTH];
  word_t            skid_q [2];
  word_t            skid_d [2];
  logic             pl_q;

  logic sel_wr, dat_wr, dat_rd, tx_in_rdy;
  logic [PW-1:0] step;
  port_width_t   new_w;

  assign sel_wr = wr_i && addr_i == REG_PORT_SEL_OFS;
  assign dat_wr = wr_i && addr_i == REG_PORT_DATA_OFS && tx_in_rdy;
  assign dat_rd = rd_i && addr_i == REG_PORT_DATA_OFS;
  assign new_w  = port_width_t'(wdata_i[WIDTH_HI_BIT:WIDTH_LO_BIT]);
  assign tx_in_rdy = !skid_q[1].valid;

  always_comb begin
    unique case (sel_q.width)
      W16:     step = PW'(2);
      W32:     step = PW'(4);
      default: step = PW'(1);
    endcase
  end

  // select register, pointer and width guard
  always_comb begin
    sel_d     = sel_q;
    ptr_d     = ptr_q;
    writing_d = writing_q;
    sel_d.restart = 1'b0;
    if (dat_wr || dat_rd) begin
      ptr_d = ptr_q + step;
      writing_d = sel_q.dir;
    end
    if (buffer_clear_cmd_i) begin
      ptr_d     = '0;
      writing_d = 1'b0;
    end
    if (sel_wr) begin
      sel_d.pipe = wdata_i[PIPE_HI_BIT:PIPE_LO_BIT];
      sel_d.dir  = wdata_i[DIR_BIT];
      if (new_w != WBAD && !(writing_q && sel_q.dir &&
          new_w > sel_q.width)) begin
        sel_d.width = new_w;
      end
      if (wdata_i[RESTART_BIT] && !sel_q.dir) begin
        ptr_d = '0;
        sel_d.restart = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q     <= '{restart: 1'b0, width: port_width_t'(WIDTH_RESET),
                     dir: 1'b0, pipe: 3'h0};
      ptr_q     <= '0;
      writing_q <= 1'b0;
    end else begin
      sel_q     <= sel_d;
      ptr_q     <= ptr_d;
      writing_q <= writing_d;
    end
  end

  // plane memory, only the active plane is addressed
  always_ff @(posedge clk_i) begin
    pl_q <= plane_sel_i;
    if (dat_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (PW'(i) < step) begin
          mem[pl_q][(ptr_q + PW'(i)) % DEPTH] <= wdata_i[8*i +: 8];
        end
      end
    end
  end

  // read data
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        REG_PORT_SEL_OFS: begin
          rdata_d[RESTART_BIT] = 1'b0;
          rdata_d[RSVD_HI_BIT:RSVD_LO_BIT] = 2'h0;
          rdata_d[WIDTH_HI_BIT:WIDTH_LO_BIT] = sel_q.width;
          rdata_d[DIR_BIT] = sel_q.dir;
          rdata_d[PIPE_HI_BIT:PIPE_LO_BIT] = sel_q.pipe;
        end
        REG_PORT_DATA_OFS: begin
          for (int i = 0; i < 4; i++) begin
            if (PW'(i) < step) begin
              rdata_d[8*i +: 8] = mem[pl_q][(ptr_q + PW'(i)) % DEPTH];
            end
          end
        end
        REG_PORT_STAT_OFS: begin
          rdata_d[0] = port_ready_flag_i;
          rdata_d[1] = writing_q;
          rdata_d[17:16] = 2'(ptr_q);
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // two-entry transmit skid buffer
  always_comb begin
    skid_d[0] = skid_q[0];
    skid_d[1] = skid_q[1];
    if (skid_q[0].valid && tx_ready_i) begin
      skid_d[0] = skid_q[1];
      skid_d[1] = '0;
    end
    if (dat_wr && sel_q.dir) begin
      if (!skid_d[0].valid) begin
        skid_d[0] = '{valid: 1'b1, data: wdata_i};
      end else begin
        skid_d[1] = '{valid: 1'b1, data: wdata_i};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skid_q[0] <= '0;
      skid_q[1] <= '0;
    end else begin
      skid_q[0] <= skid_d[0];
      skid_q[1] <= skid_d[1];
    end
  end

  assign rdata_o    = rdata_q;
  assign tx_data_o  = skid_q[0].data;
  assign tx_valid_o = skid_q[0].valid;
  assign current_pipe_select_o    = sel_q.pipe;
  assign control_pipe_direction_o = sel_q.dir;

  AST_RESTART_PTR: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_wr && wdata_i[RESTART_BIT] && !sel_q.dir && !buffer_clear_cmd_i
    |=> ptr_q == '0) else $error("restart did not zero pointer");
  AST_NO_WIDEN: assert property (@(posedge clk_i) disable iff (rst_i)
    writing_q && sel_q.dir && sel_wr
    |=> sel_q.width <= $past(sel_q.width))
    else $error("width widened during write");
  AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == REG_PORT_SEL_OFS
    |=> rdata_o[RSVD_HI_BIT:RSVD_LO_BIT] == 2'b00)
    else $error("reserved bits nonzero");
  AST_NO_BAD_W: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_q.width != WBAD) else $error("width 11 stored");
  AST_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
    dat_rd && !sel_wr && !buffer_clear_cmd_i
    |=> ptr_q == $past(ptr_q) + $past(step))
    else $error("pointer step wrong");
  AST_RX_ONLY: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_wr && wdata_i[RESTART_BIT] && sel_q.dir && !dat_wr && !dat_rd
    && !buffer_clear_cmd_i |=> ptr_q == $past(ptr_q))
    else $error("transmit pointer restarted");
endmodule

/* File: dv/fifo_sink_model.sv */
/* far side sink for transmit words.
   assumes valid/ready on clk_i; stall_i holds ready low. */
`timescale 1ns/1ps
module fifo_sink_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] tx_data_i,
  input  wire logic        tx_valid_i,
  input  wire logic        stall_i,
  output logic             tx_ready_o
);
  logic [31:0] got_q[$];
  assign tx_ready_o = !stall_i;
  always @(posedge clk_i) begin
    if (rst_i)
      got_q.delete();
    else if (tx_valid_i && tx_ready_o)
      got_q.push_back(tx_data_i);
  end
endmodule

/* File: dv/usb_fifo_port_select_ctrl_bench.sv */
/* bench for the fifo port select block.
   assumes the sink model on the transmit side. */
`timescale 1ns/1ps
module usb_fifo_port_select_ctrl_bench;
  import fifo_port_pkg::*;
  logic        clk_i, rst_i, wr_i, rd_i, clr, stall, txv, txr;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, txd, got;
  logic [2:0]  pipe_o;
  logic        dir_o;
  int          n_mismatch, num_checks, lfsr, i;
  int          exp_q[$];
  usb_fifo_port_select_ctrl #(.DEPTH(8)) dut_u (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .plane_sel_i(1'b0),
    .buffer_clear_cmd_i(clr), .port_ready_flag_i(1'b1),
    .tx_data_o(txd), .tx_valid_o(txv), .tx_ready_i(txr),
    .current_pipe_select_o(pipe_o), .control_pipe_direction_o(dir_o));
  fifo_sink_model sink_u (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(txd),
    .tx_valid_i(txv), .stall_i(stall), .tx_ready_o(txr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic int nxt();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]} & 8'hFF;
    return lfsr;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {wr_i, rd_i, clr, stall, addr_i, wdata_i} = '0;
    lfsr = 6;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_PORT_SEL_OFS);
    chk(got, 32'h0);
    wr(REG_PORT_SEL_OFS, 32'h3400);
    rd(REG_PORT_SEL_OFS);
    chk(got, 32'h0400);
    wr(REG_PORT_SEL_OFS, 32'h0C00);
    rd(REG_PORT_SEL_OFS);
    chk(got, 32'h0400);
    $display("select register test done");
    wr(REG_PORT_SEL_OFS, 32'h0001);
    rd(REG_PORT_STAT_OFS);
    chk(got[0], 1'b1);
    for (i = 0; i < 3; i++) begin
      wr(REG_PORT_SEL_OFS, 32'h4001 | (i << 10));
      wr(REG_PORT_DATA_OFS, nxt());
      rd(REG_PORT_STAT_OFS);
      chk(got[17:16], (1 << i) & 3);
    end
    wr(REG_PORT_SEL_OFS, 32'h4001);
    i = nxt();
    wr(REG_PORT_DATA_OFS, i);
    wr(REG_PORT_DATA_OFS, nxt());
    wr(REG_PORT_SEL_OFS, 32'h4001);
    rd(REG_PORT_DATA_OFS);
    chk(got[7:0], i[7:0]);
    rd(REG_PORT_STAT_OFS);
    chk(got[17:16], 2'h1);
    $display("receive restart test done");
    wr(REG_PORT_SEL_OFS, 32'h0022);
    stall <= 1'b1;
    for (i = 0; i < 3; i++) begin
      exp_q.push_back(nxt());
      wr(REG_PORT_DATA_OFS, exp_q[i]);
    end
    void'(exp_q.pop_back());
    rd(REG_PORT_STAT_OFS);
    chk(got[1], 1'b1);
    wr(REG_PORT_SEL_OFS, 32'h0822);
    rd(REG_PORT_SEL_OFS);
    chk(got, 32'h0022);
    chk(pipe_o, 32'h2);
    chk(dir_o, 1'b1);
    stall <= 1'b0;
    for (i = 0; i < 20 && sink_u.got_q.size() < 2; i++) @(posedge clk_i);
    chk(sink_u.got_q.size(), 2);
    foreach (sink_u.got_q[i]) chk(sink_u.got_q[i][7:0], exp_q[i]);
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wr(REG_PORT_SEL_OFS, 32'h0822);
    rd(REG_PORT_SEL_OFS);
    chk(got, 32'h0822);
    $display("transmit width test done");
    complete_run();
  end
endmodule
